/* File: test_wle_top.sv */
`timescale 1ns/1ps

// ==========================================================================
// Bench for the luma adjust stage
// ==========================================================================
module test_wle_top
    import wle_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         ce = 1'b1;
    logic         stall = 1'b0;
    logic         slow = 1'b1;
    wle_apb_req_s apb_r = '0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         in_valid = 1'b0;
    logic         in_ready;
    wle_pix_in_s  in_pix = '0;
    logic         out_valid;
    logic         out_ready;
    wle_pix_out_s out_pix;
    wle_pix_out_s last_act;
    int           fails = 0;
    int           n_compared = 0;

    always #4 clk = ~clk;

    wle_top u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .apb(apb_r), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready),
        .in_pix(in_pix), .out_valid(out_valid), .out_ready(out_ready), .out_pix(out_pix));

    wle_fmt_model u_fmt (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_pix(out_pix), .out_ready(out_ready),
        .last_act(last_act));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; the watchdog alone bounds the wait for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        apb_r.psel    <= 1'b1;
        apb_r.penable <= 1'b0;
        apb_r.pwrite  <= wr;
        apb_r.paddr   <= a;
        apb_r.pwdata  <= d;
        @(posedge clk);
        apb_r.penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        apb_r.psel    <= 1'b0;
        apb_r.penable <= 1'b0;
        // Idle cycle, so the next call never reassigns psel in this step
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask : rd

    // Send n samples, each held until in_ready is seen high at an edge;
    // in_valid stays high afterwards and the caller lowers it
    task automatic push(input int n, input logic [9:0] y, input logic vact);
        repeat (n)
        begin
            in_valid <= 1'b1;
            in_pix   <= '{y: y, cb: 8'h11, cr: 8'h22, vact: vact};
            do
            begin
                @(posedge clk);
            end
            while (in_ready !== 1'b1);
        end
    endtask : push

    task automatic t_reset;
        rd(12'h4c0, 32'h200, 1'b0);
        rd(12'h4c4, 32'h000, 1'b0);
        rd(12'h4c8, 32'h020, 1'b0);
        rd(12'h4cc, 32'h000, 1'b1);
        wr(12'h4c4, 32'h87f);
        rd(12'h4c4, 32'h87f, 1'b0);
    endtask : t_reset

    // Program offset and gain words, optionally latch, stream flat luma
    task automatic luma_case(input logic [11:0] offs, input logic [11:0] gain,
                             input logic strobe, input logic [9:0] y, input logic [7:0] exp);
        wr(12'h4c4, {20'h0, offs});
        wr(12'h4c8, {20'h0, gain});
        if (strobe)
            wr(12'h500, 32'h040);
        push(8, y, 1'b0);
        push(12, y, 1'b1);
        push(8, y, 1'b0);
        in_valid <= 1'b0;
        // Let the trailing samples carry the last active one out
        repeat (8) @(posedge clk);
        chk({24'h0, last_act.y}, {24'h0, exp});
        // Eleven active outputs, the last on an even phase: blue first
        chk({24'h0, last_act.c}, 32'h11);
    endtask : luma_case

    // Stall until the two-entry buffer refuses, freeze with ce low, then drain
    task automatic t_fill;
        stall    <= 1'b1;
        in_valid <= 1'b1;
        repeat (30) @(posedge clk);
        @(negedge clk);
        chk({31'h0, in_ready}, 32'h0);
        @(posedge clk);
        ce    <= 1'b0;
        stall <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk({31'h0, in_ready}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        repeat (30) @(posedge clk);
        in_valid <= 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({31'h0, in_ready}, 32'h1);
    endtask : t_fill

    task automatic give_verdict;
        $display("compared %0d, fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Watchdog; the whole run needs far fewer cycles
    initial
    begin
        #400000;
        fails++;
        give_verdict();
    end

    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        luma_case(12'h010, 12'h620, 1'b1, 10'h200, 8'd128);
        luma_case(12'h010, 12'h420, 1'b1, 10'h200, 8'd144);
        luma_case(12'h0f0, 12'h420, 1'b1, 10'h200, 8'd112);
        luma_case(12'h800, 12'h420, 1'b1, 10'h010, 8'd16);
        luma_case(12'h000, 12'h110, 1'b1, 10'h200, 8'd72);
        luma_case(12'h000, 12'h010, 1'b1, 10'h200, 8'd80);
        luma_case(12'h010, 12'h420, 1'b0, 10'h200, 8'd80);
        luma_case(12'h000, 12'h420, 1'b1, 10'h202, 8'd129);
        luma_case(12'h000, 12'h460, 1'b1, 10'h202, 8'd128);
        luma_case(12'h000, 12'h4c0, 1'b1, 10'h203, 8'd129);
        t_fill();
        give_verdict();
    end
endmodule : test_wle_top

/* File: wle_buf.sv */
`timescale 1ns/1ps

module wle_buf #(
    parameter int WIDTH = 27
) (
    input  wire logic             clk,       // Pixel clock
    input  wire logic             rst_n,     // Sync reset, active low
    input  wire logic             ce,        // Clock enable
    input  wire logic             in_valid,  // Producer has a word
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Word in
    output logic                  out_valid, // Word available
    input  wire logic             out_ready, // Consumer takes it
    output logic [WIDTH-1:0]      out_data   // Oldest word
);

    // ======================================================================
    // Elaboration check
    // ======================================================================
    if (WIDTH < 1)
    begin : g_chk
        $error("wle_buf: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic                  wr;
        logic                  rd;
        logic [1:0]            cnt;
        logic                  room;
    } wle_buf_s;

    wle_buf_s st;
    wle_buf_s next_st;
    logic     push;
    logic     pop;

    // ======================================================================
    // Two entries, so a stalled consumer never drops a word
    // ======================================================================
    always_comb
    begin
        next_st = st;
        push    = in_valid && st.room;
        pop     = out_valid && out_ready;
        if (push)
        begin
            next_st.mem[st.wr] = in_data;
            next_st.wr         = ~st.wr;
        end
        if (pop)
        begin
            next_st.rd = ~st.rd;
        end
        next_st.cnt  = 2'(st.cnt + {1'b0, push} - {1'b0, pop});
        next_st.room = (next_st.cnt != 2'd2);
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st      <= '0;
            st.room <= 1'b1;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign in_ready  = st.room;
    assign out_valid = (st.cnt != 2'd0);
    assign out_data  = st.mem[st.rd];

endmodule : wle_buf

/* File: wle_cfg.svh */
`ifndef WLE_CFG_SVH
`define WLE_CFG_SVH

// ==========================================================================
// Register indices (byte address = index * 4)
// ==========================================================================
`define WLE_IDX_SHARP      10'h130
`define WLE_IDX_OFFS       10'h131
`define WLE_IDX_GAIN       10'h132
`define WLE_IDX_CTRL       10'h140

// ==========================================================================
// Reset values
// ==========================================================================
`define WLE_RST_SHARP      12'h200
`define WLE_RST_OFFS       12'h000
`define WLE_RST_GAIN       12'h020
`define WLE_RST_PEND       1'b1

// ==========================================================================
// Field positions
// ==========================================================================
`define WLE_F_CORING       1:0
`define WLE_F_PEAK         4:2
`define WLE_B_BYP_LP       5
`define WLE_B_BYP_SKEW     6
`define WLE_B_BYP_VACT     7
`define WLE_B_SWAP         8
`define WLE_F_FREQ         10:9
`define WLE_F_OFFS         7:0
`define WLE_B_FLOOR        11
`define WLE_F_GAIN         5:0
`define WLE_F_NR           7:6
`define WLE_B_CLAMP        8
`define WLE_B_BRI_BYP      9
`define WLE_B_CON_BYP      10
`define WLE_B_LATCH        6

// ==========================================================================
// Luma levels in 8.2 fixed point, and the unity gain code
// ==========================================================================
`define WLE_CLAMP_HI       16'sd128
`define WLE_CLAMP_LO       16'sd64
`define WLE_FLOOR          16'sd64
`define WLE_YMAX           16'sd1023
`define WLE_UNITY          6'd32

`endif

/* File: wle_fmt_model.sv */
`timescale 1ns/1ps

// ==========================================================================
// Output formatter stand-in: takes samples promptly, slowly or not at all
// ==========================================================================
module wle_fmt_model
    import wle_pkg::*;
(
    input  wire logic         clk,       // Pixel clock
    input  wire logic         rst_n,     // Sync reset, active low
    input  wire logic         stall,     // Refuse every sample
    input  wire logic         slow,      // Take only every other cycle
    input  wire logic         out_valid, // Sample offered
    input  wire wle_pix_out_s out_pix,   // Sample data
    output logic              out_ready, // Sample taken
    output wle_pix_out_s      last_act   // Last active sample taken
);
    logic tog;

    // Ready pattern; slow mode exercises the back-pressure path
    assign out_ready = !stall && (!slow || tog);

    // Keep the newest active-video sample for the bench to judge
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            tog      <= 1'b0;
            last_act <= '0;
        end
        else
        begin
            tog <= ~tog;
            if (out_valid && out_ready && out_pix.vact)
                last_act <= out_pix;
        end
    end
endmodule : wle_fmt_model

/* File: wle_pkg.sv */
package wle_pkg;

    // Input sample: luma in 8.2 fixed point, both chroma parts, active flag
    typedef struct packed {
        logic [9:0] y;
        logic [7:0] cb;
        logic [7:0] cr;
        logic       vact;
    } wle_pix_in_s;

    // Output sample: 8-bit luma, multiplexed chroma
    typedef struct packed {
        logic [7:0] y;
        logic [7:0] c;
        logic       vact;
    } wle_pix_out_s;

    // APB request signals
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wle_apb_req_s;

    // The three adjustment words
    typedef struct packed {
        logic [11:0] sharp;
        logic [11:0] offs;
        logic [11:0] gain;
    } wle_cfg_s;

    typedef enum logic [1:0] {
        WLE_NR_ROUND,
        WLE_NR_TRUNC,
        WLE_NR_ACC1,
        WLE_NR_ACC2
    } wle_nr_e;

    // Whole state of the top module
    typedef struct packed {
        wle_cfg_s          shadow;
        wle_cfg_s          active;
        logic              pend;
        wle_pix_in_s [5:0] line;
        logic              phase;
        logic [1:0]        err;
        logic              out_valid;
        wle_pix_out_s      out;
        logic              pready;
        logic [31:0]       prdata;
        logic              pslverr;
    } wle_state_s;

endpackage : wle_pkg

/* File: wle_top.sv */
`timescale 1ns/1ps
`include "wle_cfg.svh"

module wle_top
    import wle_pkg::*;
(
    input  wire logic         clk,       // Pixel clock, 125 MHz
    input  wire logic         rst_n,     // Sync reset, active low
    input  wire logic         ce,        // Clock enable, freezes all state
    input  wire wle_apb_req_s apb,       // APB request
    output logic [31:0]       prdata,    // APB read data
    output logic              pready,    // APB ready
    output logic              pslverr,   // APB error, unmapped address
    input  wire logic         in_valid,  // Input sample valid
    output logic              in_ready,  // Input sample accepted
    input  wire wle_pix_in_s  in_pix,    // Input sample
    output logic              out_valid, // Output sample valid
    input  wire logic         out_ready, // Formatter takes sample
    output wle_pix_out_s      out_pix    // Output sample
);

    localparam int PW = $bits(wle_pix_in_s);

    wle_state_s        st;
    wle_state_s        next_st;
    logic              b_valid;
    logic              b_ready;
    logic [PW-1:0]     b_raw;
    wle_pix_in_s       b_pix;
    logic              adv;
    logic              take;
    logic              ctrl_wr;
    logic              hit;
    logic [11:0]       rdval;
    wle_pix_in_s [6:0] win;
    logic signed [15:0] ctr;
    logic signed [15:0] lp;
    logic signed [15:0] hf;
    logic signed [15:0] hfc;
    logic signed [15:0] boost;
    logic signed [15:0] cor;
    logic signed [15:0] y_pk;
    logic signed [15:0] y_con;
    logic signed [15:0] y_bri;
    logic signed [15:0] y_flr;
    logic signed [15:0] clamp;
    logic [7:0]         y8;
    logic [1:0]         next_err;
    logic               vact_c;

    // ======================================================================
    // Input buffer
    // ======================================================================
    // Ready towards the decoder comes from a flop inside the buffer
    wle_buf #(
        .WIDTH     (PW)
    ) u_buf (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_pix),
        .out_valid (b_valid),
        .out_ready (b_ready),
        .out_data  (b_raw)
    );

    assign b_pix = wle_pix_in_s'(b_raw);

    // ======================================================================
    // Next-state logic
    // ======================================================================
    always_comb
    begin
        next_st = st;
        // APB decode; one-cycle access phase
        hit = 1'b1;
        case (apb.paddr[11:2])
            `WLE_IDX_SHARP: rdval = st.shadow.sharp;
            `WLE_IDX_OFFS:  rdval = st.shadow.offs;
            `WLE_IDX_GAIN:  rdval = st.shadow.gain;
            `WLE_IDX_CTRL:  rdval = {5'h00, st.pend, 6'h00};
            default:
            begin
                rdval = 12'h000;
                hit   = 1'b0;
            end
        endcase
        next_st.pready = 1'b0;
        if (apb.psel && !apb.penable)
        begin
            next_st.pready  = 1'b1;
            next_st.prdata  = {20'h00000, rdval};
            next_st.pslverr = !hit;
        end
        ctrl_wr = 1'b0;
        if (apb.psel && apb.penable && st.pready && apb.pwrite && hit)
        begin
            case (apb.paddr[11:2])
                `WLE_IDX_SHARP: next_st.shadow.sharp = apb.pwdata[11:0];
                `WLE_IDX_OFFS:  next_st.shadow.offs  = apb.pwdata[11:0];
                `WLE_IDX_GAIN:  next_st.shadow.gain  = apb.pwdata[11:0];
                default:        ctrl_wr = apb.pwdata[`WLE_B_LATCH];
            endcase
        end

        // Settings move over only while no active sample is in the line,
        // so one line never mixes two settings
        take = st.pend && !st.line[0].vact && !st.line[1].vact && !st.line[2].vact
               && !st.line[3].vact && !st.line[4].vact && !st.line[5].vact;
        if (take)
        begin
            next_st.active = st.shadow;
            next_st.pend   = 1'b0;
        end
        // A new strobe in the takeover cycle wins over the clear
        if (ctrl_wr)
        begin
            next_st.pend = 1'b1;
        end

        // Sample window, newest first, centre at tap 3
        win[0] = b_pix;
        for (int k = 1; k < 7; k++)
        begin
            win[k] = st.line[k-1];
        end

        // Skew filter: half-sample interpolation on data and flag
        if (st.active.sharp[`WLE_B_BYP_SKEW])
        begin
            ctr = 16'(win[3].y);
        end
        else
        begin
            ctr = 16'(({6'h00, win[3].y} + {6'h00, win[4].y} + 16'h0001) >> 1);
        end
        vact_c = st.active.sharp[`WLE_B_BYP_VACT] ? win[3].vact
                 : (win[3].vact & win[4].vact);

        // Tap spacing sets the peaking centre frequency
        case (st.active.sharp[`WLE_F_FREQ])
            2'b00: lp = 16'((32'(ctr) * 2 + 32'(win[0].y) + 32'(win[6].y)) >>> 2);
            2'b10: lp = 16'((32'(ctr) * 2 + 32'(win[2].y) + 32'(win[4].y)) >>> 2);
            default: lp = 16'((32'(ctr) * 2 + 32'(win[1].y) + 32'(win[5].y)) >>> 2);
        endcase
        hf = ctr - lp;

        // Coring in quarter-LSB units
        case (st.active.sharp[`WLE_F_CORING])
            2'b01:   cor = 16'sd2;
            2'b10:   cor = 16'sd4;
            2'b11:   cor = 16'sd8;
            default: cor = 16'sd0;
        endcase
        if (hf > cor)
        begin
            hfc = hf - cor;
        end
        else if (hf < -cor)
        begin
            hfc = hf + cor;
        end
        else
        begin
            hfc = 16'sd0;
        end

        // Peaking boost, strength/8 of the cored detail
        boost = 16'((32'(hfc) * 32'(st.active.sharp[`WLE_F_PEAK])) >>> 3);
        y_pk  = (st.active.sharp[`WLE_B_BYP_LP] ? ctr : lp + hfc) + boost;
        if (y_pk < 16'sd0)
        begin
            y_pk = 16'sd0;
        end
        if (y_pk > `WLE_YMAX)
        begin
            y_pk = `WLE_YMAX;
        end

        // Gain around the clamp level, then offset, then floor
        clamp = st.active.gain[`WLE_B_CLAMP] ? `WLE_CLAMP_LO : `WLE_CLAMP_HI;
        if (st.active.gain[`WLE_B_CON_BYP])
        begin
            y_con = y_pk;
        end
        else
        begin
            y_con = clamp + 16'((32'(y_pk - clamp)
                    * 32'(st.active.gain[`WLE_F_GAIN])) >>> 5);
        end
        if (y_con < 16'sd0)
        begin
            y_con = 16'sd0;
        end
        if (y_con > `WLE_YMAX)
        begin
            y_con = `WLE_YMAX;
        end
        y_bri = y_con;
        if (!st.active.gain[`WLE_B_BRI_BYP])
        begin
            y_bri = y_con + 16'($signed(st.active.offs[`WLE_F_OFFS]) * 4);
        end
        if (y_bri < 16'sd0)
        begin
            y_bri = 16'sd0;
        end
        if (y_bri > `WLE_YMAX)
        begin
            y_bri = `WLE_YMAX;
        end
        y_flr = y_bri;
        if (st.active.offs[`WLE_B_FLOOR] && y_bri < `WLE_FLOOR)
        begin
            y_flr = `WLE_FLOOR;
        end

        // Reduction to 8 bits; error restarts each line
        next_err = st.err;
        case (wle_nr_e'(st.active.gain[`WLE_F_NR]))
            WLE_NR_ROUND:
            begin
                y8 = (y_flr[9:1] == 9'h1ff) ? 8'hff : 8'((y_flr[9:1] + 9'h001) >> 1);
            end
            WLE_NR_TRUNC:
            begin
                y8 = y_flr[9:2];
            end
            WLE_NR_ACC1:
            begin
                y8 = (y_flr[9:1] == 9'h1ff) ? 8'hff
                     : 8'((y_flr[9:1] + {8'h00, st.err[0]}) >> 1);
                next_err = {1'b0, y_flr[1] ^ st.err[0]};
            end
            WLE_NR_ACC2:
            begin
                y8 = (y_flr[9:2] == 8'hff) ? 8'hff
                     : 8'(({1'b0, y_flr[9:0]} + {9'h000, st.err}) >> 2);
                next_err = 2'(y_flr[1:0] + st.err);
            end
            default:
            begin
                y8 = y_flr[9:2];
            end
        endcase

        // Datapath moves one sample when the output register is free
        adv     = b_valid && (!st.out_valid || out_ready);
        b_ready = !st.out_valid || out_ready;
        if (out_ready)
        begin
            next_st.out_valid = 1'b0;
        end
        if (adv)
        begin
            next_st.line      = {st.line[4:0], b_pix};
            next_st.out_valid = 1'b1;
            next_st.out.y     = y8;
            next_st.out.vact  = vact_c;
            next_st.out.c     = (st.phase ^ st.active.sharp[`WLE_B_SWAP])
                                ? win[3].cr : win[3].cb;
            next_st.phase     = vact_c ? !st.phase : 1'b0;
            next_st.err       = vact_c ? next_err : 2'b00;
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st              <= '0;
            st.shadow.sharp <= `WLE_RST_SHARP;
            st.shadow.offs  <= `WLE_RST_OFFS;
            st.shadow.gain  <= `WLE_RST_GAIN;
            st.active.sharp <= `WLE_RST_SHARP;
            st.active.offs  <= `WLE_RST_OFFS;
            st.active.gain  <= `WLE_RST_GAIN;
            st.pend         <= `WLE_RST_PEND;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    assign prdata    = st.prdata;
    assign pready    = st.pready;
    assign pslverr   = st.pslverr;
    assign out_valid = st.out_valid;
    assign out_pix   = st.out;

    // ======================================================================
    // Assertions
    // ======================================================================
    default clocking cb_clk @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_latch_takeover: assert property (ce && take |=> st.active == $past(st.shadow))
        else $error("settings not taken over");
    a_latch_clears: assert property (ce && take && !ctrl_wr |=> !st.pend)
        else $error("update strobe not cleared");
    a_coring_none: assert property (st.active.sharp[1:0] == 2'b00 |-> hfc == hf)
        else $error("coring removed detail at code 00");
    a_peak_off: assert property (st.active.sharp[4:2] == 3'b000 |-> boost == 16'sd0)
        else $error("peaking active at code 000");
    a_gain_unity: assert property (
        !st.active.gain[10] && st.active.gain[5:0] == `WLE_UNITY |-> y_con == y_pk)
        else $error("unity gain changed luma");
    a_clamp_fixed: assert property (
        !st.active.gain[10] && y_pk == clamp
        |-> y_con == clamp && clamp == (st.active.gain[8] ? 16'sd64 : 16'sd128))
        else $error("clamp level point moved by gain");
    a_offset_skip: assert property (st.active.gain[9] |-> y_bri == y_con)
        else $error("offset added while skipped");
    // Narrow band in which no offset can saturate, so the sum must be exact
    a_offset_add: assert property (
        !st.active.gain[9] && y_con >= 16'sd512 && y_con <= 16'sd515
        |-> y_bri == y_con + 16'($signed(st.active.offs[7:0]) * 4))
        else $error("brightness offset wrong");
    a_floor_out: assert property (ce && adv && st.active.offs[11] |=> out_pix.y >= 8'd16)
        else $error("luma below floor");
    a_trunc_mode: assert property (
        ce && adv && st.active.gain[7:6] == 2'b01 |=> out_pix.y == $past(y_flr[9:2]))
        else $error("truncation mode wrong");
    a_chroma_order: assert property (
        ce && adv && !st.phase && vact_c
        |=> out_pix.c == (st.active.sharp[8] ? $past(win[3].cr) : $past(win[3].cb)))
        else $error("chroma order wrong");
    a_skew_bypass: assert property (st.active.sharp[6] |-> ctr == 16'(win[3].y))
        else $error("skew filter not bypassed");

    c_latch_used: cover property (ce && ctrl_wr ##[1:100] take);
    c_stall_full: cover property (out_valid && !out_ready && !in_ready);
    c_floor_hit: cover property (st.active.offs[11] && y_bri < `WLE_FLOOR && adv);
    c_acc2_mode: cover property (adv && st.active.gain[7:6] == 2'b11 && vact_c);

endmodule : wle_top
